// ==== hw/ipfm_pkg.sv ====
package ipfm_pkg;
    // ==========================================================
    // Register map (word index = byte address / 4 not used; plain port)
    localparam logic [3:0]  REG_UNIT_SEL     = 4'h0;
    localparam logic [3:0]  REG_COND         = 4'h1;
    localparam logic [3:0]  REG_DONE_THR     = 4'h2;
    localparam logic [3:0]  REG_APPR_THR     = 4'h3;
    localparam logic [3:0]  REG_TIME_THR     = 4'h4;
    localparam logic [3:0]  REG_HOLD_TIME    = 4'h5;
    localparam logic [3:0]  REG_FLY_CTRL     = 4'h6;
    localparam logic [3:0]  REG_FLY_DISP     = 4'h7;
    localparam logic [3:0]  REG_FLY_SPEED    = 4'h8;
    localparam logic [3:0]  REG_STATUS       = 4'h9;
    localparam logic [3:0]  REG_IRQ_STAT     = 4'hA;
    localparam logic [3:0]  REG_IRQ_MASK     = 4'hB;
    localparam logic [3:0]  REG_REF_COUNT    = 4'hC;
    // ==========================================================
    // Reset values
    localparam logic [15:0] UNIT_SEL_RST     = 16'h0000;
    localparam logic [15:0] COND_RST         = 16'h0000;
    localparam logic [15:0] DONE_THR_RST     = 16'h02DE;
    localparam logic [15:0] APPR_THR_RST     = 16'hFFFF;
    localparam logic [15:0] TIME_THR_RST     = 16'h0000;
    localparam logic [15:0] HOLD_TIME_RST    = 16'h0000;
    localparam logic [15:0] TIME_MAX         = 16'h7530;
    localparam logic [30:0] FLY_DISP_RST     = 31'h00002710;
    localparam logic [15:0] FLY_SPEED_RST    = 16'h00C8;
    localparam logic [7:0]  FLY_CTRL_RST     = 8'h12;
    localparam logic [15:0] FLY_MIN_RPM      = 16'h000A;
    // ==========================================================
    // Field positions
    localparam int FLY_EN_BIT       = 0;
    localparam int FLY_UNLOCK_BIT   = 1;
    localparam int FLY_INH_LOG_BIT  = 2;
    localparam int TRIG_EDGE_LSB    = 4;
    localparam int IRQ_FLY_DONE     = 0;
    localparam int IRQ_IN_POSITION_FLAG_RISE    = 1;
    localparam int IRQ_FLY_REFUSED  = 2;
    localparam int IRQ_W            = 3;
    // ==========================================================
    // Trigger edge modes
    localparam logic [2:0]  EDGE_FALL0 = 3'h0;
    localparam logic [2:0]  EDGE_RISE1 = 3'h1;
    localparam logic [2:0]  EDGE_RISE2 = 3'h2;
    localparam logic [2:0]  EDGE_FALL3 = 3'h3;
    localparam logic [2:0]  EDGE_BOTH  = 3'h4;
    // ==========================================================
    // Timing
    localparam int CLK_HZ        = 20000000;
    localparam int TICK_MS       = 1;
    localparam int MS_CYCLES     = CLK_HZ / 1000 * TICK_MS;
    localparam int CTRL_NS       = 1000;
    localparam int CTRL_CYCLES   = (CTRL_NS * (CLK_HZ / 1000000) + 999) / 1000;

    typedef enum logic [1:0] {IPFM_IDLE, IPFM_RUN, IPFM_LOCKED} ipfm_fly_e;
endpackage : ipfm_pkg

// ==== hw/ipfm_core.sv ====
`timescale 1ns/1ns
// Overview of operation
// RULE_01: Unit selector picks encoder or reference counts
// RULE_02: Condition selector chooses among four output cases
// RULE_03: In-position when deviation under done threshold
// RULE_04: Approach when deviation under approach threshold
// RULE_05: Both flags invalid without servo-on
// RULE_06: Millisecond time threshold and hold time
// RULE_07: Host maps outputs to functions 22,5,6
// RULE_08: Fly move refused while homing active
// RULE_09: Trigger starts fixed move, original direction
// RULE_10: Other references ignored during fly move
// RULE_11: Reference counter counts fly pulses only; code also counts external pulses passed while idle
// RULE_12: Unlock setting decides post-move blocking; drops refs
// RULE_13: Fly done and in-position asserted together
// RULE_14: Needs speed at least 10 RPM, speed nonzero
// RULE_15: Needs nonzero displacement and no inhibit
// RULE_16: Fast trigger input only, forced edge mode
// RULE_17: Zero hold keeps flag until next reference
// RULE_18: Per control cycle, absolute value, strict less
module ipfm_core
    import ipfm_pkg::*;
#(
    parameter int CTRL_DIV = CTRL_CYCLES,
    parameter int MS_DIV   = MS_CYCLES
) (
    input  wire logic        clk,               // 20 MHz clock
    input  wire logic        rst,               // Async reset, active high
    input  wire logic [3:0]  reg_addr,          // Register index
    input  wire logic [31:0] reg_wdata,         // Write data
    input  wire logic        reg_wr,            // Write strobe
    input  wire logic        reg_rd,            // Read strobe
    output logic      [31:0] reg_rdata,         // Read data, cycle after strobe
    input  wire logic        servo_on,          // Servo-on pin
    input  wire logic        pos_mode,          // Position control mode active
    input  wire logic        homing_active,     // Homing in use
    input  wire logic [31:0] dev_enc,           // Signed deviation, encoder units
    input  wire logic [31:0] dev_ref,           // Signed deviation, reference units
    input  wire logic        ref_filt_zero,     // Filtered reference is zero
    input  wire logic        ref_raw_zero,      // Raw reference is zero
    input  wire logic        ref_pulse_in,      // External reference pulse
    input  wire logic        ref_dir_in,        // External reference direction
    input  wire logic [15:0] motor_rpm,         // Absolute motor speed
    input  wire logic        fast_trigger_input,// Fast trigger pin
    input  wire logic        fly_inhibit_input, // Inhibit pin
    input  wire logic        fly_unlock_input,  // Unlock pin
    output logic             ref_pulse_out,     // Reference pulse to loop
    output logic             ref_dir_out,       // Reference direction to loop
    output logic [15:0]      fly_speed_out,     // Fly constant speed, RPM
    output logic             in_position_flag,  // Positioning done
    output logic             approach_flag,     // Positioning near
    output logic             fly_move_done_flag,// Fly move completed
    output logic             reference_done_flag,// No reference pending
    output logic             irq                // Level interrupt
);
    // ==========================================================
    // Synchronisers
    logic [1:0] trig_s, inh_s, unl_s, son_s;
    logic       trig_d;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            trig_s <= 2'h0;
            inh_s  <= 2'h0;
            unl_s  <= 2'h0;
            son_s  <= 2'h0;
            trig_d <= 1'b0;
        end else begin
            trig_s <= {trig_s[0], fast_trigger_input};
            inh_s  <= {inh_s[0], fly_inhibit_input};
            unl_s  <= {unl_s[0], fly_unlock_input};
            son_s  <= {son_s[0], servo_on};
            trig_d <= trig_s[1];
        end
    end

    // ==========================================================
    // Registers
    logic [15:0] unit_reg, cond_reg, done_thr_reg, appr_thr_reg;
    logic [15:0] time_thr_reg, hold_reg, speed_reg;
    logic [30:0] disp_reg;
    logic [7:0]  fly_ctrl_reg;
    logic [IRQ_W-1:0] irq_stat_reg, irq_mask_reg, irq_ev;
    logic [31:0] ref_count_reg;
    ipfm_fly_e   fly_reg;

    // Clamp into the settable range: thresholds 1..65535, times 0..30000
    function automatic logic [15:0] clamp(input logic [15:0] v, input logic is_time);
        if (is_time)
            clamp = (v > TIME_MAX) ? TIME_MAX : v;
        else
            clamp = (v == 16'h0000) ? 16'h0001 : v;
    endfunction : clamp

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            unit_reg     <= UNIT_SEL_RST;
            cond_reg     <= COND_RST;
            done_thr_reg <= DONE_THR_RST;
            appr_thr_reg <= APPR_THR_RST;
            time_thr_reg <= TIME_THR_RST;
            hold_reg     <= HOLD_TIME_RST;
            fly_ctrl_reg <= FLY_CTRL_RST;
            disp_reg     <= FLY_DISP_RST;
            speed_reg    <= FLY_SPEED_RST;
            irq_mask_reg <= '0;
        end else if (reg_wr) begin
            case (reg_addr)
                REG_UNIT_SEL:  unit_reg     <= {15'h0000, reg_wdata[0]};        // RULE_01
                REG_COND:      cond_reg     <= {14'h0000, reg_wdata[1:0]};      // RULE_02
                REG_DONE_THR:  done_thr_reg <= clamp(reg_wdata[15:0], 1'b0);    // RULE_03
                REG_APPR_THR:  appr_thr_reg <= clamp(reg_wdata[15:0], 1'b0);    // RULE_04
                REG_TIME_THR:  time_thr_reg <= clamp(reg_wdata[15:0], 1'b1);    // RULE_06
                REG_HOLD_TIME: hold_reg     <= clamp(reg_wdata[15:0], 1'b1);    // RULE_06
                REG_FLY_CTRL: begin
                    // Enable cannot be set while homing
                    fly_ctrl_reg[FLY_EN_BIT] <= reg_wdata[FLY_EN_BIT] & ~homing_active; // RULE_08
                    fly_ctrl_reg[FLY_UNLOCK_BIT]  <= reg_wdata[FLY_UNLOCK_BIT];
                    fly_ctrl_reg[FLY_INH_LOG_BIT] <= reg_wdata[FLY_INH_LOG_BIT];
                    fly_ctrl_reg[TRIG_EDGE_LSB+:3] <=
                        (reg_wdata[TRIG_EDGE_LSB+:3] > EDGE_BOTH) ? EDGE_RISE1
                                                                  : reg_wdata[TRIG_EDGE_LSB+:3];
                end
                REG_FLY_DISP:  disp_reg  <= (reg_wdata[30:0] > 31'h40000000) ? 31'h40000000
                                                                             : reg_wdata[30:0];
                REG_FLY_SPEED: speed_reg <= (reg_wdata[15:0] > 16'h1770) ? 16'h1770
                                                                         : reg_wdata[15:0];
                REG_IRQ_MASK:  irq_mask_reg <= reg_wdata[IRQ_W-1:0];
                default: ;
            endcase
            // A write elsewhere must not let a stale enable survive homing
            if (homing_active)
                fly_ctrl_reg[FLY_EN_BIT] <= 1'b0;                               // RULE_08
        end else if (homing_active) begin
            fly_ctrl_reg[FLY_EN_BIT] <= 1'b0;                                   // RULE_08
        end
    end

    // ==========================================================
    // Control-cycle and millisecond tick dividers
    logic [15:0] ctrl_cnt, ms_cnt;
    logic        ctrl_tick, ms_tick;
    assign ctrl_tick = (ctrl_cnt == 16'(CTRL_DIV - 1));
    assign ms_tick   = (ms_cnt == 16'(MS_DIV - 1));
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_cnt <= 16'h0000;
            ms_cnt   <= 16'h0000;
        end else begin
            ctrl_cnt <= ctrl_tick ? 16'h0000 : ctrl_cnt + 16'h0001;
            ms_cnt   <= ms_tick ? 16'h0000 : ms_cnt + 16'h0001;
        end
    end

    // ==========================================================
    // Fly move sequencer
    logic        trig_edge, fly_ok, fly_start, fly_end, fly_dir_reg, fly_pulse;
    logic [30:0] fly_left_reg;
    logic [2:0]  edge_mode;
    logic        inh_active;
    assign edge_mode  = fly_ctrl_reg[TRIG_EDGE_LSB+:3];
    always_comb begin
        case (edge_mode)                                                        // RULE_16
            EDGE_FALL0, EDGE_FALL3: trig_edge = trig_d & ~trig_s[1];
            EDGE_BOTH:              trig_edge = trig_d ^ trig_s[1];
            default:                trig_edge = ~trig_d & trig_s[1];
        endcase
    end
    assign inh_active = inh_s[1] ~^ fly_ctrl_reg[FLY_INH_LOG_BIT];
    assign fly_ok = fly_ctrl_reg[FLY_EN_BIT] & son_s[1] & pos_mode & ~homing_active  // RULE_09
                  & (motor_rpm >= FLY_MIN_RPM) & (speed_reg != 16'h0000)             // RULE_14
                  & (disp_reg != 31'h00000000) & ~inh_active;                        // RULE_15
    assign fly_start = (fly_reg != IPFM_RUN) && trig_edge && fly_ok;            // RULE_10
    assign fly_pulse = (fly_reg == IPFM_RUN) && ctrl_tick;
    assign fly_end   = fly_pulse && (fly_left_reg == 31'h00000001);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fly_reg      <= IPFM_IDLE;
            fly_left_reg <= 31'h00000000;
            fly_dir_reg  <= 1'b0;
        end else begin
            case (fly_reg)
                IPFM_IDLE, IPFM_LOCKED: begin
                    if (fly_start) begin
                        fly_reg      <= IPFM_RUN;
                        fly_left_reg <= disp_reg;
                        fly_dir_reg  <= ref_dir_in;                             // RULE_09
                    end else if (fly_reg == IPFM_LOCKED && unl_s[1]) begin
                        fly_reg <= IPFM_IDLE;
                    end
                end
                IPFM_RUN: begin
                    if (fly_pulse)
                        fly_left_reg <= fly_left_reg - 31'h00000001;
                    if (fly_end)                                                // RULE_12
                        fly_reg <= fly_ctrl_reg[FLY_UNLOCK_BIT] ? IPFM_LOCKED : IPFM_IDLE;
                    else if (!son_s[1])
                        fly_reg <= IPFM_IDLE;
                end
                default: fly_reg <= IPFM_IDLE;
            endcase
        end
    end

    // External references dropped, not queued, while blocked
    logic ext_pass;
    assign ext_pass = (fly_reg == IPFM_IDLE);                                   // RULE_12
    assign ref_pulse_out = ext_pass ? ref_pulse_in : fly_pulse;                 // RULE_10
    assign ref_dir_out   = ext_pass ? ref_dir_in : fly_dir_reg;
    assign fly_speed_out = (speed_reg != 16'h0000) ? speed_reg : motor_rpm;

    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            ref_count_reg <= 32'h00000000;
        else if (fly_start)
            ref_count_reg <= 32'h00000000;
        else if (ref_pulse_out)                                                 // RULE_11
            ref_count_reg <= ref_dir_out ? ref_count_reg - 32'h00000001
                                         : ref_count_reg + 32'h00000001;
    end

    // ==========================================================
    // Deviation compare
    logic [31:0] dev_sel, dev_abs;
    logic        below_done, below_appr, cond_done, cond_appr, ref_zero;
    assign dev_sel = unit_reg[0] ? dev_ref : dev_enc;                           // RULE_01
    assign dev_abs = dev_sel[31] ? (~dev_sel + 32'h00000001) : dev_sel;         // RULE_18
    assign below_done = dev_abs < {16'h0000, done_thr_reg};                     // RULE_03
    assign below_appr = dev_abs < {16'h0000, appr_thr_reg};                     // RULE_04
    always_comb begin
        case (cond_reg[1:0])                                                    // RULE_02
            2'h0:    ref_zero = 1'b1;
            2'h1:    ref_zero = ref_filt_zero;
            default: ref_zero = ref_raw_zero;
        endcase
    end
    assign cond_done = below_done & ref_zero & (fly_reg != IPFM_RUN);
    assign cond_appr = below_appr & ref_zero;

    // ==========================================================
    // Flag timing
    logic [15:0] win_cnt, hold_cnt;
    logic        hold_on, in_position_flag_prev, hold_mode, active;
    assign hold_mode = (cond_reg[1:0] == 2'h3);
    assign active    = son_s[1] & pos_mode;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            in_position_flag   <= 1'b0;
            approach_flag      <= 1'b0;
            fly_move_done_flag <= 1'b0;
            win_cnt            <= 16'h0000;
            hold_cnt           <= 16'h0000;
            hold_on            <= 1'b0;
        end else if (!active) begin
            in_position_flag   <= 1'b0;                                         // RULE_05
            approach_flag      <= 1'b0;                                         // RULE_05
            fly_move_done_flag <= 1'b0;
            win_cnt            <= 16'h0000;
            hold_on            <= 1'b0;
        end else if (fly_end) begin
            in_position_flag   <= 1'b1;                                         // RULE_13
            fly_move_done_flag <= 1'b1;                                         // RULE_13
            hold_on  <= hold_mode;
            hold_cnt <= hold_reg;
        end else begin
            if (fly_start)
                fly_move_done_flag <= 1'b0;
            if (ms_tick && cond_done && win_cnt < time_thr_reg)                 // RULE_06
                win_cnt <= win_cnt + 16'h0001;
            else if (!cond_done)
                win_cnt <= 16'h0000;
            if (ctrl_tick) begin                                                // RULE_18
                approach_flag <= cond_appr;
                if (cond_done && win_cnt >= time_thr_reg) begin
                    in_position_flag <= 1'b1;
                    if (hold_mode && !in_position_flag) begin
                        hold_on  <= 1'b1;
                        hold_cnt <= hold_reg;
                    end
                end else if (hold_on) begin
                    if (hold_reg == 16'h0000) begin                             // RULE_17
                        if (ref_pulse_out) begin
                            hold_on          <= 1'b0;
                            in_position_flag <= 1'b0;
                        end
                    end else if (hold_cnt == 16'h0000) begin
                        hold_on          <= 1'b0;
                        in_position_flag <= 1'b0;
                    end
                end else begin
                    in_position_flag <= 1'b0;
                end
            end
            if (ms_tick && hold_on && hold_cnt != 16'h0000)                     // RULE_06
                hold_cnt <= hold_cnt - 16'h0001;
        end
    end

    assign reference_done_flag = (fly_reg != IPFM_RUN) & ref_raw_zero;

    // ==========================================================
    // Interrupts: set wins over write-one-to-clear
    assign irq_ev[IRQ_FLY_DONE]    = fly_end;
    assign irq_ev[IRQ_IN_POSITION_FLAG_RISE]   = in_position_flag & ~in_position_flag_prev;
    assign irq_ev[IRQ_FLY_REFUSED] = trig_edge & ~fly_ok & (fly_reg != IPFM_RUN);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_stat_reg <= '0;
            in_position_flag_prev    <= 1'b0;
        end else begin
            in_position_flag_prev <= in_position_flag;
            irq_stat_reg <= (irq_stat_reg & ~((reg_wr && reg_addr == REG_IRQ_STAT)
                            ? reg_wdata[IRQ_W-1:0] : '0)) | irq_ev;
        end
    end
    assign irq = |(irq_stat_reg & irq_mask_reg);

    // ==========================================================
    // Read port
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            case (reg_addr)
                REG_UNIT_SEL:  reg_rdata <= {16'h0000, unit_reg};
                REG_COND:      reg_rdata <= {16'h0000, cond_reg};
                REG_DONE_THR:  reg_rdata <= {16'h0000, done_thr_reg};
                REG_APPR_THR:  reg_rdata <= {16'h0000, appr_thr_reg};
                REG_TIME_THR:  reg_rdata <= {16'h0000, time_thr_reg};
                REG_HOLD_TIME: reg_rdata <= {16'h0000, hold_reg};
                REG_FLY_CTRL:  reg_rdata <= {24'h000000, fly_ctrl_reg};
                REG_FLY_DISP:  reg_rdata <= {1'b0, disp_reg};
                REG_FLY_SPEED: reg_rdata <= {16'h0000, speed_reg};
                REG_STATUS:    reg_rdata <= {26'h0000000, fly_reg, 1'b0, fly_move_done_flag,
                                             approach_flag, in_position_flag};
                REG_IRQ_STAT:  reg_rdata <= {29'h00000000, irq_stat_reg};
                REG_IRQ_MASK:  reg_rdata <= {29'h00000000, irq_mask_reg};
                REG_REF_COUNT: reg_rdata <= ref_count_reg;
                default:       reg_rdata <= 32'h00000000;
            endcase
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end

    // ==========================================================
    // Checks
    servo_off_a: assert property (@(posedge clk) disable iff (rst)        // RULE_05
        !son_s[1] && !rst |=> !in_position_flag && !approach_flag)
        else $error("flags valid with servo off");
    fly_done_a: assert property (@(posedge clk) disable iff (rst)         // RULE_13
        fly_end && active |=> in_position_flag && fly_move_done_flag)
        else $error("fly done without in-position");
    no_retrigger_a: assert property (@(posedge clk) disable iff (rst)     // RULE_10
        fly_reg == IPFM_RUN && !fly_pulse |=> $stable(fly_left_reg))
        else $error("fly move restarted while running");
    ref_block_a: assert property (@(posedge clk) disable iff (rst)        // RULE_12
        fly_reg != IPFM_IDLE && ref_pulse_in && !fly_pulse |-> !ref_pulse_out)
        else $error("reference passed while blocked");
    homing_a: assert property (@(posedge clk) disable iff (rst)           // RULE_08
        homing_active |=> !fly_ctrl_reg[FLY_EN_BIT])
        else $error("fly enabled during homing");
    slow_start_a: assert property (@(posedge clk) disable iff (rst)       // RULE_14
        fly_start |-> motor_rpm >= FLY_MIN_RPM && speed_reg != 16'h0000)
        else $error("fly started too slow");
    disp_start_a: assert property (@(posedge clk) disable iff (rst)       // RULE_15
        fly_start |=> fly_reg == IPFM_RUN && fly_left_reg != 31'h00000000)
        else $error("fly started with zero displacement");
    thr_range_a: assert property (@(posedge clk) disable iff (rst)        // RULE_03
        done_thr_reg != 16'h0000 && appr_thr_reg != 16'h0000 && time_thr_reg <= TIME_MAX)
        else $error("threshold out of range");
    near_cmp_a: assert property (@(posedge clk) disable iff (rst)         // RULE_04
        ctrl_tick && active && !fly_end && !below_appr |=> !approach_flag)
        else $error("approach flag above threshold");
    fly_run_c: cover property (@(posedge clk) disable iff (rst) fly_start ##[1:300] fly_end);
    in_position_flag_c:    cover property (@(posedge clk) disable iff (rst) $rose(in_position_flag));
    lock_c:    cover property (@(posedge clk) disable iff (rst) fly_reg == IPFM_LOCKED);
endmodule : ipfm_core

// ==== tb/ipfm_host.sv ====
`timescale 1ns/1ns
// ==========
// Host side: fires the trigger pin and counts loop pulses
module ipfm_host (
    input  wire logic clk,          // Bench clock
    input  wire logic fire,         // Hold high to raise the trigger pin
    input  wire logic pulse,        // Reference pulse seen at the loop
    output logic      trig = 1'b0,  // Fast trigger pin
    output int        pulses = 0    // Pulses seen since the last fire
);
    always @(posedge clk) begin
        trig   <= fire;
        pulses <= fire ? 0 : pulses + int'(pulse);
    end
endmodule : ipfm_host

// ==== tb/ipfm_tb.sv ====
`timescale 1ns/1ns
module ipfm_tb;
    import ipfm_pkg::*;
    logic        clk = 0, rst = 1, wr = 0, rd = 0, son = 0, hom = 0, fire = 0, pin = 0;
    logic [3:0]  ad = 0;
    logic [31:0] wd = 0, dev = 0, devr = 0, rdat, d;
    logic [15:0] rpm = 16'h0064, spd;
    logic        po, trig, inp, apr, fdone, irq, rdo, rdn, unl = 0, inh = 0, dir = 0;
    logic [31:0] rv[6] = '{32'h0, 32'h0, 32'h2DE, 32'hFFFF, 32'h0, 32'h0};
    int          num_errors = 0, cmp_count = 0, cyc = 0, pulses, v, n;
    ipfm_core #(.MS_DIV(20)) dut_u (.clk(clk), .rst(rst), .reg_addr(ad), .reg_wdata(wd),
        .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat), .servo_on(son), .pos_mode(1'b1),
        .homing_active(hom), .dev_enc(dev), .dev_ref(devr), .ref_filt_zero(1'b1),
        .ref_raw_zero(1'b1), .ref_pulse_in(pin), .ref_dir_in(dir), .motor_rpm(rpm),
        .fast_trigger_input(trig), .fly_inhibit_input(inh), .fly_unlock_input(unl),
        .ref_pulse_out(po), .ref_dir_out(rdo), .fly_speed_out(spd), .in_position_flag(inp),
        .approach_flag(apr), .fly_move_done_flag(fdone), .reference_done_flag(rdn),
        .irq(irq));
    ipfm_host host_u (.clk(clk), .fire(fire), .pulse(po), .trig(trig), .pulses(pulses));
    always #25 clk = ~clk;
    task automatic stop_test();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : stop_test
    task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wreg(logic [3:0] a, logic [31:0] x);
        ad <= a;
        wd <= x;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        // Let an edge pass so a following write never re-assigns the strobe in one step
        @(posedge clk);
    endtask : wreg
    // Data is taken at the edge that closes the cycle after the strobe
    task automatic rreg(logic [3:0] a);
        ad <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        d = rdat;
    endtask : rreg
    always @(posedge clk) begin
        cyc++;
        if (cyc > 20000) begin
            num_errors++;
            stop_test();
        end
    end
    initial begin
        void'($urandom(32'hDB31));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        foreach (rv[i]) begin
            rreg(4'(i));
            chk("reset value", rv[i], d);
        end
        rreg(4'hF);
        chk("unmapped", 32'h0, d);
        wreg(REG_TIME_THR, 32'd40000);
        rreg(REG_TIME_THR);
        chk("time clamp", 32'd30000, d);
        wreg(REG_TIME_THR, 32'h0);
        wreg(REG_DONE_THR, 32'd100);
        wreg(REG_APPR_THR, 32'd300);
        for (int i = 0; i < 14; i++) begin
            v = (i < 2) ? 100 - i : int'($urandom_range(800)) - 400;
            wreg(REG_UNIT_SEL, 32'(i % 2));
            dev  <= (i % 2) ? 32'd1000 : 32'(v);
            devr <= (i % 2) ? 32'(v) : 32'd1000;
            son <= (i % 5 != 4);
            repeat (80) @(posedge clk);
            v = (v < 0) ? -v : v;
            chk("in position", 32'(son && v < 100), 32'(inp));
            chk("approach", 32'(son && v < 300), 32'(apr));
        end
        devr <= 32'h0;
        son  <= 1'b1;
        wreg(REG_TIME_THR, 32'd3);
        repeat (30) @(posedge clk);
        chk("time window early", 32'h0, 32'(inp));
        repeat (70) @(posedge clk);
        chk("time window late", 32'h1, 32'(inp));
        hom <= 1'b1;
        wreg(REG_FLY_CTRL, 32'h11);
        rreg(REG_FLY_CTRL);
        chk("enable refused", 32'h0, d & 32'h1);
        hom <= 1'b0;
        // Enable, stay blocked after the move, inhibit when the pin is high, rising edge
        wreg(REG_FLY_CTRL, 32'h17);
        wreg(REG_IRQ_MASK, 32'h4);
        for (int k = 0; k < 2; k++) begin
            rpm <= k ? 16'h0064 : 16'h0005;
            inh <= k[0];
            fire <= 1'b1;
            repeat (2) @(posedge clk);
            fire <= 1'b0;
            repeat (20) @(posedge clk);
            chk("refused irq", 32'h1, 32'(irq));
            wreg(REG_IRQ_STAT, 32'h4);
            @(posedge clk);
            chk("irq cleared", 32'h0, 32'(irq));
        end
        inh  <= 1'b0;
        dir  <= 1'b1;
        devr <= 32'd500;
        wreg(REG_FLY_DISP, 32'd5);
        fire <= 1'b1;
        repeat (2) @(posedge clk);
        fire <= 1'b0;
        for (n = 0; n < 400 && fdone !== 1'b1; n++) begin
            if (n == 20) begin
                chk("ref done busy", 32'h0, 32'(rdn));
                chk("fly direction", 32'h1, 32'(rdo));
            end
            pin <= (n % 3 == 2);
            @(posedge clk);
        end
        pin <= 1'b0;
        chk("done with inpos", 32'h3, {30'h0, fdone, inp});
        chk("fly pulses", 32'd5, 32'(pulses));
        chk("ref done idle", 32'h1, 32'(rdn));
        chk("fly speed", 32'(FLY_SPEED_RST), 32'(spd));
        rreg(REG_REF_COUNT);
        chk("ref count", 32'(-5), d);
        rreg(REG_STATUS);
        chk("locked", 32'(IPFM_LOCKED), (d >> 4) & 32'h3);
        unl <= 1'b1;
        repeat (4) @(posedge clk);
        rreg(REG_STATUS);
        chk("unlocked", 32'(IPFM_IDLE), (d >> 4) & 32'h3);
        stop_test();
    end
endmodule : ipfm_tb
